// file: led_trigger_partner.sv
// led and trigger source model: stretches trigger requests, measures red pulse widths
// assumes requests change at clock edges and the sink outputs are registered
`timescale 1ns/10ps
`default_nettype none

module led_trigger_partner #(
  parameter int MIN_HOLD = 200
) (
  input  wire logic       clk_sys,
  input  wire logic [2:0] pin_request,
  input  wire logic       red_sink_out,
  output logic      [2:0] pins,
  output int              red_width,
  output int              red_pulses
);
  int stretch [3] = '{0, 0, 0};
  int run = 0;
  initial begin
    pins = 3'h0;
    red_width = 0;
    red_pulses = 0;
  end
  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (pin_request[i] && !pins[i]) stretch[i] <= MIN_HOLD;
      else if (stretch[i] > 0) stretch[i] <= stretch[i] - 1;
      pins[i] <= pin_request[i] || stretch[i] > 1;
    end
    if (red_sink_out) run <= run + 1;
    else if (run != 0) begin
      red_width <= run;
      red_pulses <= red_pulses + 1;
      run <= 0;
    end
  end
endmodule

`default_nettype wire

// file: rgb_led_defines.svh
// register map, field positions, reset values and timing counts of the led sequencer
// assumes a 200 MHz system clock; included by the package and by the core
`ifndef RGB_LED_DEFINES_SVH
`define RGB_LED_DEFINES_SVH

`define CLK_PERIOD_NS            5

`define ADDR_CHANNEL_CONTROL     8'h00
`define ADDR_RED_SINK_LEVEL      8'h01
`define ADDR_GREEN_SINK_LEVEL    8'h02
`define ADDR_BLUE_SINK_LEVEL     8'h03
`define ADDR_BOOST_SENSOR_CONFIG 8'h06
`define ADDR_SENSOR_RESULT_HIGH  8'h10
`define ADDR_SENSOR_RESULT_LOW   8'h11

`define CTL_EN_RED               0
`define CTL_EN_GREEN             1
`define CTL_EN_BLUE              2
`define CTL_AUTO                 3
`define CTL_FAST                 4
`define CTL_FADE                 5
`define CTL_SEQ_LOW              6
`define CTL_SEQ_HIGH             7
`define CTL_RESET                8'h10

`define CFG_ACTIVE               0
`define CFG_BOOST                1
`define CFG_ADAPTIVE             2
`define CFG_ACTIVE_LOAD          3
`define CFG_COMP_SRC             4
`define CFG_READOUT              5
`define CFG_RESET                8'h04
`define SINK_LEVEL_RESET         8'h00

`define PWM_MIN_PULSE_NS         200
`define PWM_TICK_CYC             ((`PWM_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWM_SLOW_STEPS           4096
`define PWM_FAST_STEPS           256
`define SEQ_SLOT_US              2500
`define SEQ_SLOT_TICKS           ((`SEQ_SLOT_US * 1000) / `PWM_MIN_PULSE_NS)
`define FADE_TIME_MS             520
`define FADE_LEVELS              256
`define FADE_STEP_CYC            ((`FADE_TIME_MS * 1000000) / (`CLK_PERIOD_NS * `FADE_LEVELS))
`define BOOST_SOFT_MS            50
`define BOOST_SOFT_CYC           ((`BOOST_SOFT_MS * 1000000) / `CLK_PERIOD_NS)
`define SENSOR_WINDOW_MS         134
`define SENSOR_SAMPLES           256
`define SENSOR_TICK_CYC          ((`SENSOR_WINDOW_MS * 1000000) / (`CLK_PERIOD_NS * `SENSOR_SAMPLES))

`endif

// file: rgb_led_pkg.sv
// types shared by the led sequencer core and its sensor averager
// assumes rgb_led_defines.svh is on the include path
`include "rgb_led_defines.svh"

package rgb_led_pkg;

  typedef enum logic [1:0] {
    mode_manual,
    mode_auto_normal,
    mode_auto_seq
  } op_mode_type;

  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        red_lvl;
    logic [7:0]        grn_lvl;
    logic [7:0]        blu_lvl;
    logic [7:0]        cfg;
    logic [7:0]        rdata;
    logic [7:0]        low_snap;
    logic [5:0]        tick_cnt;
    logic              tick;
    logic [11:0]       phase;
    logic [16:0]       sens_cnt;
    logic              sens_tick;
    logic [18:0]       fade_cnt;
    logic [8:0]        level;
    logic [23:0]       boost_cnt;
    logic              boost_soft;
    logic [2:0]        sync1;
    logic [2:0]        sync2;
    logic [2:0]        prev;
    logic [2:0]        busy;
    logic [2:0][1:0]   slot;
    logic [2:0][13:0]  slot_tick;
    logic [2:0]        sink_on;
    logic [2:0][7:0]   sink_code;
    logic [11:0]       comp_sample;
    logic              wr_seen;
  } core_state_type;

  typedef struct packed {
    logic [19:0] acc;
    logic [7:0]  count;
    logic [11:0] average;
  } average_state_type;

endpackage

// file: rgb_led_pwm_sequencer.sv
// three channel led pwm and sequencer core with register port, fade, boost and sensor control
// assumes a 200 MHz clk_sys and trigger pins that are resynchronised here
`timescale 1ns/10ps
`default_nettype none
`include "rgb_led_defines.svh"

module rgb_led_pwm_sequencer #(
  parameter int unsigned SEQ_SLOT_TICKS  = `SEQ_SLOT_TICKS,
  parameter int unsigned FADE_STEP_CYC   = `FADE_STEP_CYC,
  parameter int unsigned BOOST_SOFT_CYC  = `BOOST_SOFT_CYC,
  parameter int unsigned SENSOR_TICK_CYC = `SENSOR_TICK_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        red_trigger_in,
  input  wire logic        green_trigger_in,
  input  wire logic        blue_trigger_in,
  input  wire logic [11:0] red_duty,
  input  wire logic [11:0] green_duty,
  input  wire logic [11:0] blue_duty,
  input  wire logic [7:0]  red_stored_code,
  input  wire logic [7:0]  green_stored_code,
  input  wire logic [7:0]  blue_stored_code,
  input  wire logic        standalone_mode,
  input  wire logic [11:0] first_sensor_in,
  input  wire logic [11:0] second_sensor_in,
  output logic             red_sink_out,
  output logic             green_sink_out,
  output logic             blue_sink_out,
  output logic      [7:0]  red_sink_code,
  output logic      [7:0]  green_sink_code,
  output logic      [7:0]  blue_sink_code,
  output logic      [11:0] compensation_sample,
  output logic             compensation_source_bit,
  output logic             active_load_en,
  output logic             adaptive_vout_en,
  output logic             boost_run,
  output logic             boost_low_current,
  output logic             device_active
);

  localparam int TICK_N = `PWM_TICK_CYC;

  rgb_led_pkg::core_state_type st;
  rgb_led_pkg::core_state_type next_st;
  rgb_led_pkg::op_mode_type    mode;
  logic [1:0]                  last_slot;
  logic                        fast;
  logic                        seq_mode;
  logic                        fading;
  logic                        use_pwm;
  logic [8:0]                  target;
  logic [2:0]                  pins;
  logic [2:0]                  trig_edge;
  logic [2:0]                  pwm_on;
  logic [2:0][11:0]            duty_in;
  logic [2:0][7:0]             stored_code;
  logic [2:0][7:0]             lvl;
  logic [11:0]                 avg_first;
  logic [11:0]                 avg_second;
  logic [11:0]                 readout_sel;

  assign pins        = {blue_trigger_in, green_trigger_in, red_trigger_in};
  assign duty_in     = {blue_duty, green_duty, red_duty};
  assign stored_code = {blue_stored_code, green_stored_code, red_stored_code};
  assign lvl         = {st.blu_lvl, st.grn_lvl, st.red_lvl};
  assign trig_edge   = st.sync2 & ~st.prev;
  assign fast        = st.ctrl[`CTL_FAST];
  assign seq_mode    = (mode == rgb_led_pkg::mode_auto_seq);
  assign readout_sel = st.cfg[`CFG_READOUT] ? avg_second : avg_first;

  sensor_window_average u_avg_first (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .sample_tick (st.sens_tick),
    .sample_in   (first_sensor_in),
    .average_out (avg_first)
  );

  sensor_window_average u_avg_second (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .sample_tick (st.sens_tick),
    .sample_in   (second_sensor_in),
    .average_out (avg_second)
  );

  // operating mode from auto and sequence bits; standalone_mode forces auto normal
  always_comb begin
    case ({st.ctrl[`CTL_SEQ_HIGH], st.ctrl[`CTL_SEQ_LOW]})
      2'b00: begin
        mode      = rgb_led_pkg::mode_auto_normal;
        last_slot = 2'd0;
      end
      2'b01: begin
        mode      = rgb_led_pkg::mode_auto_seq;
        last_slot = 2'd1;
      end
      2'b10: begin
        mode      = rgb_led_pkg::mode_auto_seq;
        last_slot = 2'd2;
      end
      2'b11: begin
        mode      = rgb_led_pkg::mode_auto_seq;
        last_slot = 2'd3;
      end
      default: begin
        mode      = rgb_led_pkg::mode_auto_normal;
        last_slot = 2'd0;
      end
    endcase
    if (standalone_mode) begin
      mode = rgb_led_pkg::mode_auto_normal;
    end else if (!st.ctrl[`CTL_AUTO]) begin
      mode = rgb_led_pkg::mode_manual;
    end
  end

  assign fading  = (mode == rgb_led_pkg::mode_manual) && st.ctrl[`CTL_FADE] && (st.level != 9'h000);
  assign use_pwm = (mode != rgb_led_pkg::mode_manual) || fading;
  assign target  = (mode != rgb_led_pkg::mode_manual) ? 9'(`FADE_LEVELS) : 9'h000;

  // pulse width and placement per channel
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [20:0] prod;
    logic [11:0] duty_eff;
    logic [11:0] pos;
    logic        sub_extra;
    logic [12:0] span;
    logic [12:0] width;
    logic [12:0] pos_w;
    logic [12:0] start;
    logic        window_ok;

    assign prod      = {9'h000, duty_in[i]} * {12'h000, st.level};
    assign duty_eff  = prod[19:8];
    assign pos       = seq_mode ? st.slot_tick[i][11:0] : st.phase;
    assign sub_extra = (pos[11:8] < duty_eff[3:0]);
    assign span      = fast ? 13'(`PWM_FAST_STEPS) : 13'(`PWM_SLOW_STEPS);
    assign width     = fast ? ({5'h00, duty_eff[11:4]} + {12'h000, sub_extra})
                            : {1'b0, duty_eff};
    assign pos_w     = fast ? {5'h00, pos[7:0]} : {1'b0, pos};
    if (i == 0) begin : g_red
      assign start = 13'h0000;
    end else if (i == 1) begin : g_green
      assign start = (span - width) >> 1;
    end else begin : g_blue
      assign start = span - width;
    end
    assign window_ok = seq_mode ? (st.busy[i] && st.slot_tick[i] < 14'(`PWM_SLOW_STEPS)) : 1'b1;
    assign pwm_on[i] = window_ok && (width != 13'h0000) && (pos_w >= start) && (pos_w < start + width);
  end

  always_comb begin
    next_st           = st;
    next_st.tick      = 1'b0;
    next_st.sens_tick = 1'b0;
    // 200 ns step enable drives the shared phase counter
    if (st.tick_cnt == 6'(`PWM_TICK_CYC - 1)) begin
      next_st.tick_cnt = 6'h00;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 6'h01;
    end
    if (st.tick) begin
      next_st.phase = st.phase + 12'h001;
    end
    if (st.sens_cnt == 17'(SENSOR_TICK_CYC - 1)) begin
      next_st.sens_cnt  = 17'h00000;
      next_st.sens_tick = 1'b1;
    end else begin
      next_st.sens_cnt = st.sens_cnt + 17'h00001;
    end
    // boost soft start window
    if (!st.cfg[`CFG_BOOST]) begin
      next_st.boost_soft = 1'b0;
    end else if (st.boost_soft) begin
      if (st.boost_cnt == 24'(BOOST_SOFT_CYC - 1)) begin
        next_st.boost_soft = 1'b0;
      end else begin
        next_st.boost_cnt = st.boost_cnt + 24'h000001;
      end
    end
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_CHANNEL_CONTROL: begin
          next_st.ctrl    = reg_wdata;
          next_st.wr_seen = 1'b1;
        end
        `ADDR_RED_SINK_LEVEL:   next_st.red_lvl = reg_wdata;
        `ADDR_GREEN_SINK_LEVEL: next_st.grn_lvl = reg_wdata;
        `ADDR_BLUE_SINK_LEVEL:  next_st.blu_lvl = reg_wdata;
        `ADDR_BOOST_SENSOR_CONFIG: begin
          next_st.cfg = reg_wdata;
          if (reg_wdata[`CFG_BOOST] && !st.cfg[`CFG_BOOST]) begin
            next_st.boost_soft = 1'b1;
            next_st.boost_cnt  = 24'h000000;
          end
        end
        default: ;
      endcase
    end
    // register reads; high byte read freezes the low byte of the same result
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CHANNEL_CONTROL:     next_st.rdata = st.ctrl;
        `ADDR_RED_SINK_LEVEL:      next_st.rdata = st.red_lvl;
        `ADDR_GREEN_SINK_LEVEL:    next_st.rdata = st.grn_lvl;
        `ADDR_BLUE_SINK_LEVEL:     next_st.rdata = st.blu_lvl;
        `ADDR_BOOST_SENSOR_CONFIG: next_st.rdata = st.cfg;
        `ADDR_SENSOR_RESULT_HIGH: begin
          next_st.rdata    = {4'h0, readout_sel[11:8]};
          next_st.low_snap = readout_sel[7:0];
        end
        `ADDR_SENSOR_RESULT_LOW:   next_st.rdata = st.low_snap;
        default:                   next_st.rdata = 8'h00;
      endcase
    end
    next_st.comp_sample = st.cfg[`CFG_COMP_SRC] ? avg_second : avg_first;
    // common fade level keeps the colour balance
    if (standalone_mode) begin
      next_st.level    = 9'(`FADE_LEVELS);
      next_st.fade_cnt = 19'h00000;
    end else if (!st.ctrl[`CTL_FADE]) begin
      next_st.level    = target;
      next_st.fade_cnt = 19'h00000;
    end else if (st.level != target) begin
      if (st.fade_cnt == 19'(FADE_STEP_CYC - 1)) begin
        next_st.fade_cnt = 19'h00000;
        next_st.level    = (st.level < target) ? st.level + 9'h001 : st.level - 9'h001;
      end else begin
        next_st.fade_cnt = st.fade_cnt + 19'h00001;
      end
    end else begin
      next_st.fade_cnt = 19'h00000;
    end
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    for (int i = 0; i < 3; i++) begin
      if (!seq_mode) begin
        next_st.busy[i] = 1'b0;
      end else if (trig_edge[i]) begin
        next_st.busy[i]      = 1'b1;
        next_st.slot[i]      = 2'd0;
        next_st.slot_tick[i] = 14'h3fff;
      end else if (st.busy[i] && st.tick) begin
        if (st.slot_tick[i] == 14'(SEQ_SLOT_TICKS - 1)) begin
          next_st.slot_tick[i] = 14'h0000;
          if (st.slot[i] == last_slot) begin
            next_st.busy[i] = 1'b0;
          end else begin
            next_st.slot[i] = st.slot[i] + 2'd1;
          end
        end else begin
          next_st.slot_tick[i] = st.slot_tick[i] + 14'h0001;
        end
      end
      case (mode)
        rgb_led_pkg::mode_manual:
          next_st.sink_on[i] = st.ctrl[i] && st.sync2[i] && (!use_pwm || pwm_on[i]);
        rgb_led_pkg::mode_auto_normal:
          next_st.sink_on[i] = st.ctrl[i] && st.sync2[i] && pwm_on[i];
        rgb_led_pkg::mode_auto_seq:
          next_st.sink_on[i] = st.ctrl[i] && pwm_on[i];
        default:
          next_st.sink_on[i] = 1'b0;
      endcase
      if (!(st.cfg[`CFG_ACTIVE] || standalone_mode)) begin
        next_st.sink_on[i] = 1'b0;
      end
      next_st.sink_code[i] = (mode == rgb_led_pkg::mode_manual && !fading) ? lvl[i]
                                                                           : stored_code[i];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st         <= '0;
      st.ctrl    <= `CTL_RESET;
      st.cfg     <= `CFG_RESET;
      st.red_lvl <= `SINK_LEVEL_RESET;
      st.grn_lvl <= `SINK_LEVEL_RESET;
      st.blu_lvl <= `SINK_LEVEL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata               = st.rdata;
  assign red_sink_out            = st.sink_on[0];
  assign green_sink_out          = st.sink_on[1];
  assign blue_sink_out           = st.sink_on[2];
  assign red_sink_code           = st.sink_code[0];
  assign green_sink_code         = st.sink_code[1];
  assign blue_sink_code          = st.sink_code[2];
  assign compensation_sample     = st.comp_sample;
  assign compensation_source_bit = st.cfg[`CFG_COMP_SRC];
  assign active_load_en          = st.cfg[`CFG_ACTIVE_LOAD];
  assign adaptive_vout_en        = st.cfg[`CFG_ADAPTIVE];
  assign boost_run               = st.cfg[`CFG_BOOST];
  assign boost_low_current       = st.boost_soft;
  assign device_active           = st.cfg[`CFG_ACTIVE];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence red_trigger_armed;
    seq_mode && trig_edge[0];
  endsequence

  sequence red_sequence_started;
    st.busy[0] && st.slot[0] == 2'd0 && st.slot_tick[0] == 14'h3fff;
  endsequence

  chk_tick_spacing: assert property (st.tick |-> ##TICK_N st.tick)
    else $error("pwm step spacing wrong");
  chk_fast_default: assert property (!st.wr_seen |-> st.ctrl[`CTL_FAST])
    else $error("fast pwm not selected after reset");
  chk_seq_start: assert property (red_trigger_armed |=> red_sequence_started)
    else $error("trigger edge did not restart sequence");
  chk_seq_length: assert property (seq_mode && $fell(st.busy[0]) |-> $past(st.slot[0]) == last_slot)
    else $error("sequence ended on wrong slot");
  chk_enable_gate: assert property (!st.ctrl[`CTL_EN_RED] |=> !red_sink_out)
    else $error("red output active while disabled");
  chk_manual_dc: assert property (mode == rgb_led_pkg::mode_manual && !use_pwm && st.cfg[`CFG_ACTIVE]
    && st.ctrl[`CTL_EN_GREEN] && st.sync2[1] |=> green_sink_out)
    else $error("manual mode dc drive missing");
  chk_red_start: assert property (mode == rgb_led_pkg::mode_auto_normal && st.cfg[`CFG_ACTIVE]
    && st.ctrl[`CTL_EN_RED] && st.sync2[0] && st.phase == 12'h000
    && g_ch[0].width != 13'h0000 |=> red_sink_out)
    else $error("red pulse not at cycle start");
  chk_auto_codes: assert property (mode != rgb_led_pkg::mode_manual |=> red_sink_code == $past(red_stored_code))
    else $error("register code used outside manual mode");
  chk_readout_pair: assert property (reg_rd && reg_addr == `ADDR_SENSOR_RESULT_HIGH
    |=> st.low_snap == $past(readout_sel[7:0]) && reg_rdata == {4'h0, $past(readout_sel[11:8])})
    else $error("result bytes not from one sample");
  chk_boost_soft: assert property ($rose(st.cfg[`CFG_BOOST]) |-> boost_low_current)
    else $error("boost soft start not entered");
  chk_fade_step: assert property (st.ctrl[`CTL_FADE] && !standalone_mode && $past(st.ctrl[`CTL_FADE])
    |-> (st.level == $past(st.level) || st.level == $past(st.level) + 9'h001
      || st.level == $past(st.level) - 9'h001))
    else $error("fade level jumped");

endmodule

`default_nettype wire

// file: rgb_led_pwm_sequencer_tb_top.sv
// testbench of the led sequencer: registers, reset, boost, modes, pwm width, sensors
// assumes led_trigger_partner on the trigger pins and shortened timing parameters
`timescale 1ns/10ps
`default_nettype none

module rgb_led_pwm_sequencer_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
    logic [3:0] o;
  } row_type;
  logic        clk_sys, arst_n, reg_wr, reg_rd, standalone_mode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [7:0]  red_stored_code, green_stored_code, blue_stored_code;
  logic [7:0]  red_sink_code, green_sink_code, blue_sink_code;
  logic [11:0] red_duty, green_duty, blue_duty, first_sensor_in, second_sensor_in;
  logic [11:0] compensation_sample;
  logic        red_sink_out, green_sink_out, blue_sink_out, compensation_source_bit;
  logic        active_load_en, adaptive_vout_en, boost_run, boost_low_current, device_active;
  logic [2:0]  hold, pins;
  int          failures = 0, n_checks = 0, cyc = 0, width, pulses, n, p0;
  row_type     rows [8] = '{'{8'h01, 8'h55, 8'h55, 4'h4}, '{8'h02, 8'haa, 8'haa, 4'h4},
    '{8'h03, 8'hff, 8'hff, 4'h4}, '{8'h05, 8'h77, 8'h00, 4'h4}, '{8'h06, 8'h0c, 8'h0c, 4'hc},
    '{8'h00, 8'h40, 8'h40, 4'hc}, '{8'h00, 8'h80, 8'h80, 4'hc}, '{8'h00, 8'hc7, 8'hc7, 4'hc}};
  logic [7:0]  ra [4] = '{8'h00, 8'h06, 8'h01, 8'h03};
  logic [7:0]  rv [4] = '{8'h10, 8'h04, 8'h00, 8'h00};

  rgb_led_pwm_sequencer #(.SEQ_SLOT_TICKS(300), .FADE_STEP_CYC(4), .BOOST_SOFT_CYC(20),
    .SENSOR_TICK_CYC(4)) DUT (.clk_sys, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .red_trigger_in(pins[0]), .green_trigger_in(pins[1]),
    .blue_trigger_in(pins[2]), .red_duty, .green_duty, .blue_duty, .red_stored_code,
    .green_stored_code, .blue_stored_code, .standalone_mode, .first_sensor_in,
    .second_sensor_in, .red_sink_out, .green_sink_out, .blue_sink_out, .red_sink_code,
    .green_sink_code, .blue_sink_code, .compensation_sample, .compensation_source_bit,
    .active_load_en, .adaptive_vout_en, .boost_run, .boost_low_current, .device_active);
  led_trigger_partner LED (.clk_sys, .pin_request(hold), .red_sink_out, .pins,
    .red_width(width), .red_pulses(pulses));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, standalone_mode, hold, reg_addr, reg_wdata} = '0;
    {red_duty, green_duty, blue_duty} = '0;
    {red_stored_code, green_stored_code, blue_stored_code} = {8'ha7, 8'h3c, 8'h5e};
    {first_sensor_in, second_sensor_in} = {12'h9c3, 12'h2e5};
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].e);
      chk({active_load_en, adaptive_vout_en, boost_run, device_active}, rows[i].o);
    end
    $display("test registers done");
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    $display("test reset done");
    wr(8'h06, 8'h03);
    n = 0;
    repeat (40) begin
      #1 n += boost_low_current;
      @(posedge clk_sys);
    end
    chk(16'(n), 16'd20);
    chk({boost_run, device_active}, 2'b11);
    $display("test boost done");
    wr(8'h01, 8'h55);
    wr(8'h00, 8'h01);
    hold <= 3'b011;
    repeat (300) @(posedge clk_sys);
    chk({green_sink_out, red_sink_out, red_sink_code}, {2'b01, 8'h55});
    hold <= 3'b000;
    repeat (300) @(posedge clk_sys);
    chk(red_sink_out, 1'b0);
    $display("test manual done");
    wr(8'h00, 8'h19);
    wr(8'h01, 8'h11);
    red_duty <= 12'h010;
    hold <= 3'b001;
    repeat (4) @(posedge clk_sys);
    chk(red_sink_code, 8'ha7);
    p0 = pulses;
    n = 0;
    while (pulses < p0 + 2 && n < 30000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(16'(width), 16'd40);
    $display("test pwm done");
    hold <= 3'b000;
    wr(8'h00, 8'h59);
    repeat (4) @(posedge clk_sys);
    p0 = pulses;
    n = 0;
    hold <= 3'b001;
    @(posedge clk_sys);
    hold <= 3'b000;
    while (pulses == p0 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(16'(width), 16'd40);
    chk(n < 100, 1'b1);
    repeat (25000) @(posedge clk_sys);
    chk(16'(pulses - p0), 16'd4);
    $display("test sequence done");
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h31);
    repeat (8) @(posedge clk_sys);
    chk(red_sink_code, 8'ha7);
    repeat (1100) @(posedge clk_sys);
    chk(red_sink_code, 8'h00);
    standalone_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(red_sink_code, 8'ha7);
    $display("test fade done");
    rd(8'h10);
    chk(d, 8'h09);
    rd(8'h11);
    chk(d, 8'hc3);
    chk(compensation_sample, 12'h9c3);
    wr(8'h06, 8'h33);
    rd(8'h10);
    chk(d, 8'h02);
    rd(8'h11);
    chk(d, 8'he5);
    chk({compensation_source_bit, compensation_sample}, {1'b1, 12'h2e5});
    $display("test sensors done");
    conclude();
  end
endmodule

`default_nettype wire

// file: sensor_window_average.sv
// boxcar average of 256 sensor samples taken on a slow enable
// assumes sample_tick is a one-cycle pulse spaced a window / 256 apart
`timescale 1ns/10ps
`default_nettype none

module sensor_window_average (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        sample_tick,
  input  wire logic [11:0] sample_in,
  output logic      [11:0] average_out
);

  rgb_led_pkg::average_state_type st;
  rgb_led_pkg::average_state_type next_st;
  logic [19:0]                    sum;

  assign sum = st.acc + {8'h00, sample_in};

  always_comb begin
    next_st = st;
    if (sample_tick) begin
      next_st.count = st.count + 8'h01;
      next_st.acc   = sum;
      if (st.count == 8'hff) begin
        next_st.average = sum[19:8];
        next_st.acc     = 20'h00000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign average_out = st.average;

  chk_window_update: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(sample_tick && st.count == 8'hff) |=> $stable(st.average))
    else $error("average changed outside window end");

endmodule

`default_nettype wire
